// File: dv/cpu_core_model.sv
`default_nettype none
module cpu_core_model (
  input  wire logic sys_clk_i,
  input  wire logic long_call_instr_i,
  output logic      instr_done_o,
  output logic      call_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r;
  initial begin
    instr_done_o = 1'h0;
    call_ack_o = 1'h0;
    cnt_r = 2'h0;
  end
  // Fastest core: one-cycle instructions, so latency limits show plainly
  always @(negedge sys_clk_i) begin
    cnt_r <= long_call_instr_i ? cnt_r + 2'h1 : 2'h0;
    call_ack_o <= long_call_instr_i && cnt_r == 2'h3;
    instr_done_o <= !long_call_instr_i;
  end
endmodule
`default_nettype wire

// File: dv/irq_controller_props.sv
`default_nettype none
module irq_controller_props
  import irq_ctrl_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        global_irq_enable_i,
  input wire logic        instr_done_i,
  input wire logic        call_ack_i,
  input wire logic        long_call_instr_o,
  input wire logic [15:0] vector_o,
  input wire logic [3:0]  local_flags_o,
  input wire logic [16:0] priority_select_bits_o,
  input wire logic [1:0]  active_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence done_s;
    long_call_instr_o && call_ack_i;
  endsequence
  call_hold_a: assert property (long_call_instr_o && !call_ack_i |=> long_call_instr_o && $stable(vector_o))
    else $error("call request dropped early");
  call_drop_a: assert property (done_s |=> !long_call_instr_o)
    else $error("call request held after ack");
  vector_map_a: assert property (long_call_instr_o |-> vector_o[2:0] == 3'h3 && vector_o <= 16'h0083)
    else $error("vector off the table");
  global_gate_a: assert property (!global_irq_enable_i && !long_call_instr_o |=> !long_call_instr_o)
    else $error("call while globally disabled");
  high_block_a: assert property (active_level_o == 2'b11 && !long_call_instr_o |=> !long_call_instr_o)
    else $error("high routine preempted");
  take_edge_a: assert property ($rose(long_call_instr_o) |-> $past(instr_done_i))
    else $error("call not at instruction end");
  level_set_a: assert property (done_s |=> active_level_o != 2'b00)
    else $error("no level after call");
  pin_clear_a: assert property (done_s ##0 (vector_o == 16'h0003) |=> !local_flags_o[0])
    else $error("pin flag not cleared");
  prio_reset_a: assert property ($rose(rst_n_i) |-> priority_select_bits_o == 17'h00000)
    else $error("priority not low after reset");
endmodule
bind irq_controller irq_controller_props chk (
  .sys_clk_i              (sys_clk_i),
  .rst_n_i                (rst_n_i),
  .global_irq_enable_i    (global_irq_enable_i),
  .instr_done_i           (instr_done_i),
  .call_ack_i             (call_ack_i),
  .long_call_instr_o      (long_call_instr_o),
  .vector_o               (vector_o),
  .local_flags_o          (local_flags_o),
  .priority_select_bits_o (priority_select_bits_o),
  .active_level_o         (active_level_o)
);
`default_nettype wire

// File: dv/two_level_interrupt_controller_test.sv
`default_nettype none
module two_level_interrupt_controller_test import irq_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = '0, rst_n_i = '0, global_irq_enable_i = '0, prio_wr_i = '0;
  logic        ext_irq_pin_zero_i = '0, ext_irq_pin_one_i = '0, timer_zero_overflow_i = '0;
  logic        timer_one_overflow_i = '0, serial_rx_flag_i = '0, serial_tx_flag_i = '0;
  logic        timer_two_high_overflow_flag_i = '0, timer_two_low_overflow_flag_i = '0;
  logic        port_match_i = '0, capsense_done_flag_i = '0, capsense_greater_flag_i = '0;
  logic        return_from_irq_instr_i = '0, instr_done_i, call_ack_i, long_call_instr_o;
  logic [3:0]  flag_set_i = '0, flag_clr_i = '0, local_flags_o;
  logic [16:0] periph_pending_i = '0, source_enable_i = '0, prio_wdata_i = '0, priority_select_bits_o;
  logic [15:0] vector_o;
  logic [1:0]  active_level_o;
  int          error_cnt = 0, checks_done = 0;
  irq_controller dut (
    .sys_clk_i                      (sys_clk_i),
    .rst_n_i                        (rst_n_i),
    .ext_irq_pin_zero_i             (ext_irq_pin_zero_i),
    .ext_irq_pin_one_i              (ext_irq_pin_one_i),
    .timer_zero_overflow_i          (timer_zero_overflow_i),
    .timer_one_overflow_i           (timer_one_overflow_i),
    .serial_rx_flag_i               (serial_rx_flag_i),
    .serial_tx_flag_i               (serial_tx_flag_i),
    .timer_two_high_overflow_flag_i (timer_two_high_overflow_flag_i),
    .timer_two_low_overflow_flag_i  (timer_two_low_overflow_flag_i),
    .port_match_i                   (port_match_i),
    .periph_pending_i               (periph_pending_i),
    .capsense_done_flag_i           (capsense_done_flag_i),
    .capsense_greater_flag_i        (capsense_greater_flag_i),
    .flag_set_i                     (flag_set_i),
    .flag_clr_i                     (flag_clr_i),
    .global_irq_enable_i            (global_irq_enable_i),
    .source_enable_i                (source_enable_i),
    .prio_wr_i                      (prio_wr_i),
    .prio_wdata_i                   (prio_wdata_i),
    .instr_done_i                   (instr_done_i),
    .return_from_irq_instr_i        (return_from_irq_instr_i),
    .call_ack_i                     (call_ack_i),
    .long_call_instr_o              (long_call_instr_o),
    .vector_o                       (vector_o),
    .local_flags_o                  (local_flags_o),
    .priority_select_bits_o         (priority_select_bits_o),
    .active_level_o                 (active_level_o)
  );
  cpu_core_model core (.sys_clk_i(sys_clk_i), .long_call_instr_i(long_call_instr_o),
                       .instr_done_o(instr_done_i), .call_ack_o(call_ack_i));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (long_call_instr_o !== v && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask
  task automatic do_ret();
    return_from_irq_instr_i = 1'h1;
    @(negedge sys_clk_i);
    return_from_irq_instr_i = 1'h0;
  endtask
  task automatic drive(input int s, input logic v);
    case (s)
      0: ext_irq_pin_zero_i = v;
      1: timer_zero_overflow_i = v;
      2: ext_irq_pin_one_i = v;
      3: timer_one_overflow_i = v;
      4: serial_tx_flag_i = v;
      5: timer_two_low_overflow_flag_i = v;
      8: port_match_i = v;
      15: capsense_done_flag_i = v;
      16: capsense_greater_flag_i = v;
      default: periph_pending_i[s] = v;
    endcase
  endtask
  task automatic t_reset();
    check(priority_select_bits_o, 17'h00000);
    check(vector_o, 16'h0000);
    check(active_level_o, 2'b00);
    global_irq_enable_i = 1'h1;
    source_enable_i = 17'h1ffff;
    $display("reset test done");
  endtask
  // Every source in turn; slots 13 and 14 hold nothing
  task automatic t_vectors();
    int n;
    for (int s = 0; s < 17; s++) begin
      if (s == 13 || s == 14)
        continue;
      drive(s, 1'h1);
      @(negedge sys_clk_i);
      if (s < 4)
        drive(s, 1'h0);
      wait_lvl(1'h1, n);
      if (s < 4)
        check(17'(n), 17'(DETECT_CYCLES));
      check(vector_o, 17'(16'h0003 + 16'h0008 * s));
      wait_lvl(1'h0, n);
      check(17'(n), 17'(CALL_CYCLES));
      check(active_level_o, 2'b01);
      check(local_flags_o, 4'h0);
      if (s == 16) begin
        do_ret();
        wait_lvl(1'h1, n);
        check(17'(n), 17'h00001);
        check(vector_o, 16'h0083);
        wait_lvl(1'h0, n);
      end
      drive(s, 1'h0);
      do_ret();
      check(active_level_o, 2'b00);
    end
    $display("vector test done");
  endtask
  task automatic t_arb();
    int n;
    prio_wdata_i = 17'h00020;
    prio_wr_i = 1'h1;
    global_irq_enable_i = 1'h0;
    flag_set_i = 4'ha;
    timer_two_high_overflow_flag_i = 1'h1;
    @(negedge sys_clk_i);
    prio_wr_i = 1'h0;
    flag_set_i = 4'h0;
    repeat (3) @(negedge sys_clk_i);
    check(priority_select_bits_o, 17'h00020);
    check(local_flags_o, 4'ha);
    check(long_call_instr_o, 1'h0);
    global_irq_enable_i = 1'h1;
    wait_lvl(1'h1, n);
    check(vector_o, 16'h002b);
    wait_lvl(1'h0, n);
    repeat (4) @(negedge sys_clk_i);
    check(long_call_instr_o, 1'h0);
    timer_two_high_overflow_flag_i = 1'h0;
    do_ret();
    wait_lvl(1'h1, n);
    check(vector_o, 16'h000b);
    wait_lvl(1'h0, n);
    timer_two_high_overflow_flag_i = 1'h1;
    wait_lvl(1'h1, n);
    check(vector_o, 16'h002b);
    wait_lvl(1'h0, n);
    timer_two_high_overflow_flag_i = 1'h0;
    flag_clr_i = 4'h8;
    do_ret();
    flag_clr_i = 4'h0;
    check(active_level_o, 2'b01);
    do_ret();
    repeat (4) @(negedge sys_clk_i);
    check(long_call_instr_o, 1'h0);
    check(active_level_o, 2'b00);
    $display("arbitration test done");
  endtask
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    t_reset();
    t_vectors();
    t_arb();
    give_verdict();
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: rtl/irq_arbiter.sv
`default_nettype none
module irq_arbiter
  import irq_ctrl_pkg::*;
(
  input  wire logic [16:0] request_i,
  input  wire logic [16:0] prio_i,
  irq_req_if.arb           req
);
  // ******************************************
  // Fixed order within each level
  // ******************************************
  function automatic logic [5:0] first_set(input logic [16:0] v);
    first_set = 6'h00;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 5'(i)};
      end
    end
  endfunction

  logic [5:0] hi_pick;
  logic [5:0] lo_pick;

  always_comb begin
    hi_pick = first_set(request_i & prio_i);
    lo_pick = first_set(request_i & ~prio_i);
    req.valid = hi_pick[5] | lo_pick[5];
    req.high  = hi_pick[5];
    req.order = hi_pick[5] ? hi_pick[4:0] : lo_pick[4:0];
  end
endmodule
`default_nettype wire

// File: rtl/irq_controller.sv
// Notes on behaviour
// - Fifteen sources, each with its own vector, plus reset entry.
// - Software-set pending flag requests and vectors like a hardware one.
// - Each source has one priority bit: low or high.
// - High preempts low routine; nothing preempts a high routine.
// - All priority bits select low after reset.
// - Simultaneous requests: high level granted before low.
// - Equal level: smallest order number wins, 0 to 16.
// - Requests sampled and priority decoded every clock.
// - Best case five clocks: one detect, four for the long call.
// - Pending at return: one more instruction before the long call.
// - Worst case eighteen clocks: 1 + 5 return + 8 divide + 4 call.
// - Equal or lower level waits for return plus one instruction.
// - Reset vector 0x0000; sources at 0x0003 plus eight times order.
// - Hardware clears only external pin and timer 0/1 flags.
// - Global enable gates every source.
// - Pending flags set whatever the enables.
// - Flag still set after return raises a new request at once.
`default_nettype none
module irq_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Peripheral condition pulses
  input  wire logic        ext_irq_pin_zero_i,
  input  wire logic        ext_irq_pin_one_i,
  input  wire logic        timer_zero_overflow_i,
  input  wire logic        timer_one_overflow_i,
  // Flags held by their peripherals
  input  wire logic        serial_rx_flag_i,
  input  wire logic        serial_tx_flag_i,
  input  wire logic        timer_two_high_overflow_flag_i,
  input  wire logic        timer_two_low_overflow_flag_i,
  input  wire logic        port_match_i,
  input  wire logic [16:0] periph_pending_i,
  input  wire logic        capsense_done_flag_i,
  input  wire logic        capsense_greater_flag_i,
  // Software access to the four local flags
  input  wire logic [3:0]  flag_set_i,
  input  wire logic [3:0]  flag_clr_i,
  // Configuration
  input  wire logic        global_irq_enable_i,
  input  wire logic [16:0] source_enable_i,
  input  wire logic        prio_wr_i,
  input  wire logic [16:0] prio_wdata_i,
  // Core sequencer
  input  wire logic        instr_done_i,
  input  wire logic        return_from_irq_instr_i,
  input  wire logic        call_ack_i,
  output logic             long_call_instr_o,
  output logic [15:0]      vector_o,
  output logic [3:0]       local_flags_o,
  output logic [16:0]      priority_select_bits_o,
  output logic [1:0]       active_level_o
);
  // ******************************************
  // State
  // ******************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_CALL  = 2'b01,
    ST_HOLD  = 2'b11
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [3:0]  flags;
    logic [16:0] prio;
    logic        in_low;
    logic        in_high;
    logic        saved_low;
    logic        call;
    logic [15:0] vector;
    logic [4:0]  order;
    logic        grant_high;
  } state_t;

  // ******************************************
  // Call entry and routine exit
  // ******************************************
  function automatic state_t start_call(input state_t s, input logic [4:0] order, input logic high);
    state_t t;
    t            = s;
    t.phase      = ST_CALL;
    t.call       = 1'b1;
    t.order      = order;
    t.grant_high = high;
    t.vector     = vector_of(order);
    return t;
  endfunction

  // A nested high return drops back to the low routine underneath
  function automatic state_t end_routine(input state_t s);
    state_t t;
    t       = s;
    t.phase = ST_HOLD;
    if (s.in_high) begin
      t.in_high = 1'b0;
    end else begin
      t.in_low = 1'b0;
    end
    return t;
  endfunction

  state_t     s_r;
  state_t     s_nxt;
  logic [16:0] request;
  logic [16:0] pend;

  irq_req_if  req ();

  irq_arbiter u_arb (
    .request_i (request),
    .prio_i    (s_r.prio),
    .req       (req.arb)
  );

  // ******************************************
  // Request vector
  // ******************************************
  always_comb begin
    pend = periph_pending_i & SLOT_PRESENT;
    pend[ORDER_EXT0] = s_r.flags[0];
    pend[ORDER_TMR0] = s_r.flags[1];
    pend[ORDER_EXT1] = s_r.flags[2];
    pend[ORDER_TMR1] = s_r.flags[3];
    pend[ORDER_SERIAL] = serial_rx_flag_i | serial_tx_flag_i;
    pend[ORDER_TMR2]   = timer_two_high_overflow_flag_i | timer_two_low_overflow_flag_i;
    pend[ORDER_MATCH]  = port_match_i;
    pend[ORDER_CSDONE] = capsense_done_flag_i;
    pend[ORDER_CSGRT]  = capsense_greater_flag_i;
    request = global_irq_enable_i ? (pend & source_enable_i & SLOT_PRESENT) : 17'h00000;
  end

  // ******************************************
  // Sequencer
  // ******************************************
  logic [3:0] cond;
  logic       may_take;
  logic       take_call;
  logic       ret_done;

  always_comb begin
    s_nxt = s_r;
    cond  = {timer_one_overflow_i, ext_irq_pin_one_i, timer_zero_overflow_i, ext_irq_pin_zero_i};
    s_nxt.flags = (s_r.flags & ~flag_clr_i) | cond | flag_set_i;
    if (prio_wr_i) begin
      s_nxt.prio = prio_wdata_i;
    end
    may_take  = !s_r.in_high && (req.high || !s_r.in_low);
    take_call = req.valid && may_take && instr_done_i && !return_from_irq_instr_i;
    ret_done  = instr_done_i && return_from_irq_instr_i;
    unique case (s_r.phase)
      ST_RUN: begin
        if (take_call) begin
          s_nxt = start_call(s_nxt, req.order, req.high);
        end else if (ret_done) begin
          s_nxt = end_routine(s_nxt);
        end
      end
      ST_CALL: begin
        if (call_ack_i) begin
          s_nxt.phase = ST_RUN;
          s_nxt.call  = 1'b0;
          if (s_r.grant_high) begin
            s_nxt.in_high = 1'b1;
          end else begin
            s_nxt.in_low = 1'b1;
          end
          if (HW_CLEARED[s_r.order]) begin
            s_nxt.flags[s_r.order[1:0]] = cond[s_r.order[1:0]] | flag_set_i[s_r.order[1:0]];
          end
        end
      end
      ST_HOLD: begin
        if (ret_done) begin
          // The instruction after a return may be a return too
          s_nxt = end_routine(s_nxt);
        end else if (take_call) begin
          s_nxt = start_call(s_nxt, req.order, req.high);
        end else if (instr_done_i) begin
          s_nxt.phase = ST_RUN;
        end
      end
      default: begin
        s_nxt.phase = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.prio   <= PRIO_RESET;
      s_r.vector <= RESET_VECTOR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************************
  // Outputs
  // ******************************************
  assign long_call_instr_o      = s_r.call;
  assign vector_o               = s_r.vector;
  assign local_flags_o          = s_r.flags;
  assign priority_select_bits_o = s_r.prio;
  assign active_level_o         = s_r.in_high ? LVL_HIGH : (s_r.in_low ? LVL_LOW : LVL_NONE);
endmodule
`default_nettype wire

// File: rtl/irq_ctrl_pkg.sv
`default_nettype none
package irq_ctrl_pkg;
  // ******************************************
  // Source table
  // ******************************************
  localparam int unsigned NUM_SOURCES = 15;
  localparam int unsigned NUM_SLOTS   = 17;
  localparam int unsigned ORDER_W     = 5;
  localparam logic [4:0] ORDER_EXT0   = 5'h00;
  localparam logic [4:0] ORDER_TMR0   = 5'h01;
  localparam logic [4:0] ORDER_EXT1   = 5'h02;
  localparam logic [4:0] ORDER_TMR1   = 5'h03;
  localparam logic [4:0] ORDER_SERIAL = 5'h04;
  localparam logic [4:0] ORDER_TMR2   = 5'h05;
  localparam logic [4:0] ORDER_MATCH  = 5'h08;
  localparam logic [4:0] ORDER_CSDONE = 5'h0f;
  localparam logic [4:0] ORDER_CSGRT  = 5'h10;
  // Slots 13 and 14 hold no source
  localparam logic [16:0] SLOT_PRESENT = 17'h19fff;
  localparam logic [16:0] HW_CLEARED   = 17'h0000f;
  // ******************************************
  // Vectors and reset values
  // ******************************************
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE  = 16'h0003;
  localparam logic [15:0] VECTOR_STEP  = 16'h0008;
  localparam logic [16:0] PRIO_RESET   = 17'h00000;
  // ******************************************
  // Timing, in system clocks
  // ******************************************
  localparam int unsigned DETECT_CYCLES = 1;
  localparam int unsigned CALL_CYCLES   = 4;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b11
  } level_t;

  function automatic logic [15:0] vector_of(input logic [4:0] order);
    vector_of = VECTOR_BASE + 16'(order) * VECTOR_STEP;
  endfunction
endpackage
`default_nettype wire

// File: rtl/irq_req_if.sv
`default_nettype none
interface irq_req_if;
  logic        valid;
  logic        high;
  logic [4:0]  order;
  modport arb (output valid, output high, output order);
  modport ctl (input valid, input high, input order);
endinterface
`default_nettype wire
